// ===== inc/rmd_pkg.sv
// Constants and types of the receive DMA call controller
package rmd_pkg;
	localparam logic [15:0] CMD_ENABLE = 16'h5101;
	localparam logic [15:0] CMD_DISABLE = 16'h5102;
	localparam int ARG_FORCE_BIT = 0;
	localparam int RES_DONE_BIT = 29;
	localparam logic [1:0] DIS_OK = 2'h0;
	localparam logic [1:0] DIS_INVALID = 2'h1;
	localparam logic [1:0] DIS_RECEIVING = 2'h2;
	localparam logic [1:0] DIS_ALREADY = 2'h3;
	localparam logic [15:0] XFER_MIN_BYTES = 16'h0004;
	localparam logic [15:0] XFER_MAX_BYTES = 16'h0800;
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 16;
	localparam logic [3:0] RELEASE_CYCLES = 4'h4;
	localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
	typedef enum logic [1:0] {CALL_IDLE = 2'b01, CALL_EXEC = 2'b10} rmd_call_t;
	typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_PASS = 3'b010, RX_DROP = 3'b100} rmd_rx_t;
endpackage

// ===== inc/rmd_fifo_if.sv
// Carrier between the controller and its frame FIFO
`timescale 1ns/1ps
`default_nettype none
interface rmd_fifo_if #(parameter int W = 33, parameter int D = 16);
	logic wrValid;
	logic wrReady;
	logic [W-1:0] wrData;
	logic rdValid;
	logic rdReady;
	logic [W-1:0] rdData;
	logic flush;
	logic [$clog2(D):0] level;
	modport fifo (input wrValid, input wrData, input rdReady, input flush,
		output wrReady, output rdValid, output rdData, output level);
	modport user (output wrValid, output wrData, output rdReady, output flush,
		input wrReady, input rdValid, input rdData, input level);
endinterface
`default_nettype wire

// ===== design/rmd_fifo.sv
// Frame data FIFO with flush
`timescale 1ns/1ps
`default_nettype none
module rmd_fifo #(
	parameter int W = 33,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	rmd_fifo_if.fifo f
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_ff [DEPTH];
	logic [W-1:0] nxt_mem [DEPTH];
	logic [AW-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
	logic [AW:0] count_ff, nxt_count;
	logic doWrite, doRead;

	assign f.wrReady = count_ff < (AW+1)'(DEPTH);
	assign f.rdValid = count_ff != '0;
	assign f.rdData = mem_ff[rdPtr_ff];
	assign f.level = count_ff;

	always_comb begin
		doWrite = f.wrValid && f.wrReady;
		doRead = f.rdValid && f.rdReady;
		nxt_mem = mem_ff;
		nxt_wrPtr = wrPtr_ff;
		nxt_rdPtr = rdPtr_ff;
		nxt_count = count_ff;
		if (f.flush) begin
			// Flush drops everything, including a write in the same cycle
			nxt_wrPtr = '0;
			nxt_rdPtr = '0;
			nxt_count = '0;
		end else begin
			if (doWrite) begin
				nxt_mem[wrPtr_ff] = f.wrData;
				nxt_wrPtr = wrPtr_ff + 1'b1;
			end
			if (doRead) begin
				nxt_rdPtr = rdPtr_ff + 1'b1;
			end
			nxt_count = count_ff + (AW+1)'(doWrite) - (AW+1)'(doRead);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else begin
			mem_ff <= nxt_mem;
			wrPtr_ff <= nxt_wrPtr;
			rdPtr_ff <= nxt_rdPtr;
			count_ff <= nxt_count;
		end
	end
endmodule
`default_nettype wire

// ===== design/rmd_rx_dma_ctrl.sv
// Receive DMA call controller: enable and disable calls, frame path into buffer memory
// Notes on behaviour
// - An enable call while DMA is enabled or a buffer release is still running ends as an invalid call.
// - A transfer of fewer than 4 or more than 2048 bytes raises an exception and is not moved.
// - Command code 5102h selects the disable call, which stops DMA from the MAC FIFO.
// - A forced disable discards the frame in flight, records no buffer identifier and releases the buffer.
// - A disable without force keeps the current buffer and releases nothing.
// - A disable without force is refused while a frame is being received.
// - A forced disable resets DMA even mid-frame when enabled, and does nothing when already disabled.
// - The disable result in bits 1:0 is 00 success, 01 invalid, 10 receiving, 11 already disabled.
// - Bit 29 of the result reads 0 while the call executes and 1 once it has completed.
// - Code 5101h enables DMA, which then moves each frame of 4 to 2048 bytes and acquires a buffer for it.
`timescale 1ns/1ps
`default_nettype none
module rmd_rx_dma_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic callValid,
	input wire logic [15:0] cmdCode,
	input wire logic [31:0] callArg,
	input wire logic [31:0] reservedArg,
	output logic [31:0] resultWord,
	output logic [31:0] secondaryResult,
	input wire logic macValid,
	input wire logic [rmd_pkg::DATA_W-1:0] macData,
	input wire logic macLast,
	input wire logic [15:0] macFrameBytes,
	output logic macReady,
	output logic memValid,
	output logic [rmd_pkg::DATA_W-1:0] memData,
	output logic memLast,
	input wire logic memReady,
	output logic bufAcquire,
	output logic bufRelease,
	output logic bufIdStrobe,
	output logic [15:0] buffer_identifier_register,
	output logic dmaEnabled,
	output logic xferError
);
	import rmd_pkg::*;
	localparam logic [4:0] READY_LIMIT = 5'(FIFO_DEPTH - 2);

	function automatic logic sizeOk(input logic [15:0] bytes);
		return (bytes >= XFER_MIN_BYTES) && (bytes <= XFER_MAX_BYTES);
	endfunction

	rmd_fifo_if #(.W(DATA_W + 1), .D(FIFO_DEPTH)) fq ();
	rmd_fifo #(.W(DATA_W + 1), .DEPTH(FIFO_DEPTH)) uFifo (
		.clk(clk),
		.rst(rst),
		.f(fq)
	);

	rmd_call_t call_ff, nxt_call;
	rmd_rx_t rx_ff, nxt_rx;
	logic [15:0] cmd_ff, nxt_cmd;
	logic [31:0] arg_ff, nxt_arg, rsv_ff, nxt_rsv, result_ff, nxt_result;
	logic enabled_ff, nxt_enabled, macReady_ff, nxt_macReady;
	logic [3:0] release_ff, nxt_release;
	logic memValid_ff, nxt_memValid, memLast_ff, nxt_memLast;
	logic [DATA_W-1:0] memData_ff, nxt_memData;
	logic acquire_ff, nxt_acquire, relPulse_ff, nxt_relPulse;
	logic idStrobe_ff, nxt_idStrobe, xferErr_ff, nxt_xferErr;
	logic [15:0] buffer_identifier_register_ff, nxt_buffer_identifier_register, frameCnt_ff, nxt_frameCnt;
	logic beat, firstBeat, releasing, rxBusy, forcing, outFree, exec, force_bit;

	//////////////////////////////////////////////////////////////////////////////
	always_comb begin
		beat = macValid && macReady_ff;
		firstBeat = beat && rx_ff == RX_IDLE;
		releasing = release_ff != '0;
		rxBusy = rx_ff != RX_IDLE || fq.rdValid || memValid_ff;
		exec = call_ff == CALL_EXEC;
		force_bit = arg_ff[ARG_FORCE_BIT];
		forcing = exec && cmd_ff == CMD_DISABLE && rsv_ff == '0 && force_bit && enabled_ff && !releasing;
		outFree = !memValid_ff || memReady;
		nxt_call = call_ff;
		nxt_cmd = cmd_ff;
		nxt_arg = arg_ff;
		nxt_rsv = rsv_ff;
		nxt_result = result_ff;
		nxt_enabled = enabled_ff;
		nxt_release = releasing ? release_ff - 4'h1 : release_ff;
		nxt_relPulse = 1'b0;
		nxt_acquire = 1'b0;
		nxt_idStrobe = 1'b0;
		nxt_buffer_identifier_register = buffer_identifier_register_ff;
		nxt_frameCnt = frameCnt_ff;
		nxt_xferErr = xferErr_ff;
		nxt_rx = rx_ff;
		unique case (call_ff)
			CALL_IDLE: begin
				if (callValid) begin
					nxt_cmd = cmdCode;
					nxt_arg = callArg;
					nxt_rsv = reservedArg;
					nxt_result = RESULT_RESET;
					nxt_call = CALL_EXEC;
				end
			end
			CALL_EXEC: begin
				nxt_call = CALL_IDLE;
				nxt_result = '0;
				nxt_result[RES_DONE_BIT] = 1'b1;
				if (rsv_ff != '0) begin
					nxt_result[0] = 1'b1;
				end else if (cmd_ff == CMD_ENABLE) begin
					if (enabled_ff || releasing) begin
						nxt_result[0] = 1'b1;
					end else begin
						nxt_enabled = 1'b1;
						nxt_xferErr = 1'b0;
					end
				end else if (cmd_ff == CMD_DISABLE) begin
					if (releasing) begin
						nxt_result[1:0] = DIS_INVALID;
					end else if (force_bit) begin
						if (!enabled_ff) begin
							nxt_result[1:0] = DIS_ALREADY;
						end else begin
							// Forced reset: drop the frame and hand the buffer back
							nxt_enabled = 1'b0;
							nxt_relPulse = 1'b1;
							nxt_release = RELEASE_CYCLES;
							nxt_result[1:0] = DIS_OK;
						end
					end else if (rxBusy) begin
						nxt_result[1:0] = DIS_RECEIVING;
					end else begin
						// Buffer stays held; nothing is released here
						nxt_enabled = 1'b0;
						nxt_result[1:0] = DIS_OK;
					end
				end else begin
					nxt_result[0] = 1'b1;
				end
			end
		endcase
		if (firstBeat) begin
			if (!sizeOk(macFrameBytes)) begin
				nxt_xferErr = 1'b1;
				nxt_rx = macLast ? RX_IDLE : RX_DROP;
			end else if (forcing) begin
				nxt_rx = macLast ? RX_IDLE : RX_DROP;
			end else begin
				nxt_acquire = 1'b1;
				nxt_rx = macLast ? RX_IDLE : RX_PASS;
			end
		end else if (beat) begin
			nxt_rx = macLast ? RX_IDLE : rx_ff;
			if (forcing && !macLast) begin
				nxt_rx = RX_DROP;
			end
		end else if (forcing && rx_ff == RX_PASS) begin
			nxt_rx = RX_DROP;
		end
		// Ready is registered and drops at 14 words, so one more word gets in and one word of headroom is left in the FIFO
		nxt_macReady = nxt_rx == RX_DROP ||
			(nxt_enabled && fq.level < READY_LIMIT && (nxt_rx == RX_PASS || !firstBeat || macLast));
		fq.wrValid = beat && !forcing && (rx_ff == RX_PASS || (firstBeat && sizeOk(macFrameBytes)));
		fq.wrData = {macLast, macData};
		fq.flush = forcing;
		fq.rdReady = outFree && !forcing;
		nxt_memValid = memValid_ff;
		nxt_memData = memData_ff;
		nxt_memLast = memLast_ff;
		if (forcing) begin
			nxt_memValid = 1'b0;
		end else if (outFree) begin
			nxt_memValid = fq.rdValid;
			nxt_memData = fq.rdData[DATA_W-1:0];
			nxt_memLast = fq.rdData[DATA_W];
		end
		if (!forcing && memValid_ff && memReady && memLast_ff) begin
			nxt_idStrobe = 1'b1;
			nxt_buffer_identifier_register = frameCnt_ff;
			nxt_frameCnt = frameCnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			call_ff <= CALL_IDLE;
			rx_ff <= RX_IDLE;
			cmd_ff <= '0;
			arg_ff <= '0;
			rsv_ff <= '0;
			result_ff <= RESULT_RESET;
			enabled_ff <= 1'b0;
			macReady_ff <= 1'b0;
			release_ff <= '0;
			memValid_ff <= 1'b0;
			memData_ff <= '0;
			memLast_ff <= 1'b0;
			acquire_ff <= 1'b0;
			relPulse_ff <= 1'b0;
			idStrobe_ff <= 1'b0;
			buffer_identifier_register_ff <= '0;
			frameCnt_ff <= '0;
			xferErr_ff <= 1'b0;
		end else begin
			call_ff <= nxt_call;
			rx_ff <= nxt_rx;
			cmd_ff <= nxt_cmd;
			arg_ff <= nxt_arg;
			rsv_ff <= nxt_rsv;
			result_ff <= nxt_result;
			enabled_ff <= nxt_enabled;
			macReady_ff <= nxt_macReady;
			release_ff <= nxt_release;
			memValid_ff <= nxt_memValid;
			memData_ff <= nxt_memData;
			memLast_ff <= nxt_memLast;
			acquire_ff <= nxt_acquire;
			relPulse_ff <= nxt_relPulse;
			idStrobe_ff <= nxt_idStrobe;
			buffer_identifier_register_ff <= nxt_buffer_identifier_register;
			frameCnt_ff <= nxt_frameCnt;
			xferErr_ff <= nxt_xferErr;
		end
	end

	assign resultWord = result_ff;
	assign secondaryResult = RESULT_RESET;
	assign macReady = macReady_ff;
	assign memValid = memValid_ff;
	assign memData = memData_ff;
	assign memLast = memLast_ff;
	assign bufAcquire = acquire_ff;
	assign bufRelease = relPulse_ff;
	assign bufIdStrobe = idStrobe_ff;
	assign buffer_identifier_register = buffer_identifier_register_ff;
	assign dmaEnabled = enabled_ff;
	assign xferError = xferErr_ff;

	//////////////////////////////////////////////////////////////////////////////
	property p_callDone;
		@(posedge clk) disable iff (rst) call_ff == CALL_IDLE && callValid |=> !resultWord[29] ##1 resultWord[29];
	endproperty
	a_callDone: assert property (p_callDone) else $error("call completion bit wrong");
	property p_enableTwice;
		@(posedge clk) disable iff (rst) exec && cmd_ff == CMD_ENABLE && (enabled_ff || releasing) |=> resultWord[0];
	endproperty
	a_enableTwice: assert property (p_enableTwice) else $error("reentrant enable not refused");
	property p_sizeErr;
		// An earlier good frame may still sit in the output stage, so watch the FIFO write instead
		@(posedge clk) disable iff (rst) firstBeat && !sizeOk(macFrameBytes) |-> !fq.wrValid ##1 (xferError && !bufAcquire);
	endproperty
	a_sizeErr: assert property (p_sizeErr) else $error("bad transfer size not trapped");
	property p_disableOk;
		@(posedge clk) disable iff (rst)
			exec && cmd_ff == CMD_DISABLE && rsv_ff == '0 && !force_bit && !rxBusy && !releasing |=> !dmaEnabled && !bufRelease;
	endproperty
	a_disableOk: assert property (p_disableOk) else $error("plain disable misbehaved");
	property p_forced;
		@(posedge clk) disable iff (rst) forcing |=> bufRelease && !dmaEnabled && !memValid && !bufIdStrobe;
	endproperty
	a_forced: assert property (p_forced) else $error("forced disable did not discard");
	property p_noRelease;
		@(posedge clk) disable iff (rst) bufRelease |-> $past(forcing);
	endproperty
	a_noRelease: assert property (p_noRelease) else $error("buffer released without force");
	property p_refuseBusy;
		@(posedge clk) disable iff (rst) exec && cmd_ff == CMD_DISABLE && rsv_ff == '0 && !force_bit && rxBusy &&
			!releasing |=> resultWord[1:0] == 2'h2 && dmaEnabled == $past(enabled_ff);
	endproperty
	a_refuseBusy: assert property (p_refuseBusy) else $error("disable not refused mid-frame");
	property p_already;
		@(posedge clk) disable iff (rst) exec && cmd_ff == CMD_DISABLE && rsv_ff == '0 && force_bit && !enabled_ff &&
			!releasing |=> resultWord[1:0] == 2'h3 && !bufRelease;
	endproperty
	a_already: assert property (p_already) else $error("already-disabled code wrong");
	property p_zeroBits;
		@(posedge clk) disable iff (rst) resultWord[28:2] == '0 && resultWord[31:30] == '0 && secondaryResult == '0;
	endproperty
	a_zeroBits: assert property (p_zeroBits) else $error("unused result bits not zero");
	property p_enableOk;
		@(posedge clk) disable iff (rst) exec && cmd_ff == CMD_ENABLE && rsv_ff == '0 && !enabled_ff && !releasing
			|=> dmaEnabled && resultWord == 32'h2000_0000;
	endproperty
	a_enableOk: assert property (p_enableOk) else $error("enable call failed");
	property p_releaseBusy;
		@(posedge clk) disable iff (rst) exec && cmd_ff == CMD_DISABLE && rsv_ff == '0 && releasing
			|=> resultWord[1:0] == 2'h1;
	endproperty
	a_releaseBusy: assert property (p_releaseBusy) else $error("disable during release not invalid");
	c_frame: cover property (@(posedge clk) disable iff (rst) bufIdStrobe);
	c_forcedMid: cover property (@(posedge clk) disable iff (rst) forcing && rx_ff == RX_PASS);
	c_refused: cover property (@(posedge clk) disable iff (rst) exec && cmd_ff == CMD_DISABLE && rxBusy);
	c_fifoFull: cover property (@(posedge clk) disable iff (rst) !fq.wrReady);
endmodule
`default_nettype wire

// ===== test/rmd_mem_sink.sv
// Buffer memory sink model that can stall the write stream
`timescale 1ns/1ps
`default_nettype none
module rmd_mem_sink (
	input wire logic clk,
	input wire logic rst,
	input wire logic stall,
	input wire logic memValid,
	input wire logic [31:0] memData,
	input wire logic memLast,
	output logic memReady,
	output logic [15:0] words,
	output logic [15:0] frames,
	output logic [31:0] lastWord
);
	// Ready trails stall by a cycle, as a busy memory arbiter would
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			memReady <= 1'b0;
			words <= 16'h0000;
			frames <= 16'h0000;
			lastWord <= 32'h0000_0000;
		end else begin
			memReady <= !stall;
			if (memValid && memReady) begin
				words <= words + 16'h0001;
				lastWord <= memData;
				if (memLast) begin
					frames <= frames + 16'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Call and frame scenarios for the receive DMA call controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rmd_pkg::*;
	logic clk, rst, callValid, macValid, macLast, macReady, memValid, memLast, memReady;
	logic bufAcquire, bufRelease, bufIdStrobe, dmaEnabled, xferError, stall;
	logic [15:0] cmdCode, macFrameBytes, buffer_identifier_register, words, frames;
	logic [31:0] callArg, reservedArg, resultWord, secondaryResult, macData, memData, lastWord;
	int bad_count = 0;
	int comparisons = 0;
	int acqCnt = 0;
	int relCnt = 0;
	int idCnt = 0;
	int a;
	logic [15:0] sizes [4] = '{16'h0003, 16'h0004, 16'h0800, 16'h0801};
	logic errs [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

	rmd_rx_dma_ctrl u_dut (.clk(clk), .rst(rst), .callValid(callValid), .cmdCode(cmdCode),
		.callArg(callArg), .reservedArg(reservedArg), .resultWord(resultWord),
		.secondaryResult(secondaryResult), .macValid(macValid), .macData(macData), .macLast(macLast),
		.macFrameBytes(macFrameBytes), .macReady(macReady), .memValid(memValid), .memData(memData),
		.memLast(memLast), .memReady(memReady), .bufAcquire(bufAcquire), .bufRelease(bufRelease),
		.bufIdStrobe(bufIdStrobe), .buffer_identifier_register(buffer_identifier_register), .dmaEnabled(dmaEnabled), .xferError(xferError));
	rmd_mem_sink u_sink (.clk(clk), .rst(rst), .stall(stall), .memValid(memValid), .memData(memData),
		.memLast(memLast), .memReady(memReady), .words(words), .frames(frames), .lastWord(lastWord));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (bufAcquire === 1'b1) acqCnt <= acqCnt + 1;
		if (bufRelease === 1'b1) relCnt <= relCnt + 1;
		if (bufIdStrobe === 1'b1) idCnt <= idCnt + 1;
	end

	task automatic conclude;
		if (bad_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// One call: result clears while executing, final word lands one edge later
	task automatic call(input logic [15:0] cmd, input logic [31:0] arg, input logic [31:0] rsv,
		input logic [31:0] exp);
		@(posedge clk);
		callValid <= 1'b1;
		cmdCode <= cmd;
		callArg <= arg;
		reservedArg <= rsv;
		@(posedge clk);
		callValid <= 1'b0;
		cmdCode <= ~cmd;
		callArg <= ~arg;
		#1 chk(32'(resultWord[RES_DONE_BIT]), 32'h0, "busy flag");
		@(posedge clk);
		#1 chk(resultWord, exp, "result word");
		chk(secondaryResult, 32'h0, "secondary");
	endtask

	// Beats held until accepted; ready is looked at where it is settled
	task automatic frame(input int n, input logic [15:0] bytes, input logic fin);
		int i;
		int t;
		@(posedge clk);
		macValid <= 1'b1;
		macFrameBytes <= bytes;
		for (i = 0; i < n; i++) begin
			macData <= 32'hA500_0000 + 32'(i);
			macLast <= fin && (i == n - 1);
			t = 0;
			@(negedge clk);
			while (macReady !== 1'b1 && t < 400) begin
				t++;
				@(negedge clk);
			end
			if (t >= 400) begin
				bad_count++;
				conclude();
			end
			@(posedge clk);
		end
		macValid <= 1'b0;
		macLast <= 1'b0;
		macData <= ~macData;
	endtask

	task automatic waitIds(input int k);
		int t;
		t = 0;
		while (idCnt < k && t < 400) begin
			t++;
			@(posedge clk);
		end
		#1 chk(32'(idCnt), 32'(k), "delivered frames");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		callValid = 1'b0;
		cmdCode = 16'h0000;
		callArg = 32'h0;
		reservedArg = 32'h0;
		macValid = 1'b0;
		macData = 32'h0;
		macLast = 1'b0;
		macFrameBytes = 16'h0000;
		stall = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 chk(resultWord, RESULT_RESET, "reset result");
		call(CMD_DISABLE, 32'h1, 32'h0, 32'h2000_0003);
		call(CMD_DISABLE, 32'h0, 32'h0, 32'h2000_0000);
		call(16'h5103, 32'h0, 32'h0, 32'h2000_0001);
		call(CMD_ENABLE, 32'h0, 32'h1, 32'h2000_0001);
		chk(32'(dmaEnabled), 32'h0, "enabled by bad call");
		call(CMD_ENABLE, 32'h0, 32'h0, 32'h2000_0000);
		chk(32'(dmaEnabled), 32'h1, "not enabled");
		call(CMD_ENABLE, 32'h0, 32'h0, 32'h2000_0001);
		// Sink stalls: FIFO fills until refused, a plain disable is refused meanwhile
		fork
			frame(20, 16'h0050, 1'b1);
			begin
				repeat (40) @(posedge clk);
				#1 chk(32'(macReady), 32'h0, "full fifo accepts");
				call(CMD_DISABLE, 32'h0, 32'h0, 32'h2000_0002);
				chk(32'(dmaEnabled), 32'h1, "refused disable stopped dma");
				@(posedge clk);
				stall <= 1'b0;
			end
		join
		waitIds(1);
		chk(32'(buffer_identifier_register), 32'h0, "first buffer id");
		chk(32'(words), 32'd20, "words moved");
		chk(lastWord, 32'hA500_0013, "last word");
		chk(32'(frames), 32'h1, "frames delivered");
		chk(32'(acqCnt), 32'h1, "buffer acquires");
		call(CMD_DISABLE, 32'h0, 32'h0, 32'h2000_0000);
		chk(32'(dmaEnabled), 32'h0, "still enabled");
		chk(32'(relCnt), 32'h0, "plain disable released");
		// Forced disable in mid-frame
		call(CMD_ENABLE, 32'h0, 32'h0, 32'h2000_0000);
		@(posedge clk);
		stall <= 1'b1;
		frame(2, 16'h0010, 1'b0);
		repeat (4) @(posedge clk);
		call(CMD_DISABLE, 32'h1, 32'h0, 32'h2000_0000);
		// The release pulse stands only this cycle; the counter catches it one edge later
		chk(32'(bufRelease), 32'h1, "no release");
		chk(32'(dmaEnabled), 32'h0, "forced disable kept dma");
		call(CMD_ENABLE, 32'h0, 32'h0, 32'h2000_0001);
		frame(1, 16'h0010, 1'b1);
		@(posedge clk);
		stall <= 1'b0;
		repeat (10) @(posedge clk);
		#1 chk(32'(idCnt), 32'h1, "discarded frame got an id");
		chk(32'(words), 32'd20, "discarded data written");
		chk(32'(relCnt), 32'h1, "release count");
		repeat (8) @(posedge clk);
		call(CMD_ENABLE, 32'h0, 32'h0, 32'h2000_0000);
		// Forced disable while idle, then a disable inside the release window
		call(CMD_DISABLE, 32'h1, 32'h0, 32'h2000_0000);
		call(CMD_DISABLE, 32'h0, 32'h0, 32'h2000_0001);
		chk(32'(dmaEnabled), 32'h0, "second forced disable kept dma");
		repeat (8) @(posedge clk);
		call(CMD_ENABLE, 32'h0, 32'h0, 32'h2000_0000);
		// Transfer size limits at both edges
		for (int k = 0; k < 4; k++) begin
			a = acqCnt;
			frame(1, sizes[k], 1'b1);
			repeat (3) @(posedge clk);
			#1 chk(32'(xferError), 32'(errs[k]), "size error flag");
			chk(32'(acqCnt - a), 32'(!errs[k]), "acquire on sized frame");
			repeat (10) @(posedge clk);
			if (errs[k]) begin
				call(CMD_DISABLE, 32'h0, 32'h0, 32'h2000_0000);
				call(CMD_ENABLE, 32'h0, 32'h0, 32'h2000_0000);
				chk(32'(xferError), 32'h0, "error not cleared");
			end
		end
		conclude();
	end

	initial begin
		#100000;
		bad_count++;
		conclude();
	end
endmodule
`default_nettype wire
